// ### verilog/eth_tx_dma_ctrl.sv
// transmit dma control register, run/stop control and link-side frame control
// Operation
// - registers are 32 bits, little-endian byte lanes
// - reads accept any byte-enable pattern
// - writes other than byte, aligned 16-bit or 32-bit get target abort
// - burst-size field bits 29:24 limits words per dma transaction
// - burst size zero means unlimited, reset value zero
// - bit 18 enables udp checksum generation
// - bit 17 enables tcp checksum generation
// - bit 16 enables ip header checksum generation
// - bit 9 in full duplex sends pause when receive buffer near overflow
// - bit 9 in half duplex applies backpressure instead
// - bit 9 clear means no pause and no backpressure
// - bit 2 pads frames shorter than 64 bytes
// - padding forces fcs appending on
// - bit 1 appends computed fcs to each frame
// - bit 0 enables and runs the transmit dma engine
// - clearing enable finishes current frame, then stops
// - stop request acts only while running
`timescale 1ns/1ns
`default_nettype none
module eth_tx_dma_ctrl
    import eth_tx_ctrl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // register port
    input  wire logic        csr_sel,
    input  wire logic        csr_write,
    input  wire logic [7:0]  csr_addr,
    input  wire logic [3:0]  pci_byte_enables,
    input  wire logic [31:0] csr_wdata,
    output var  logic [31:0] csr_rdata,
    output var  logic        csr_ack,
    output var  logic        csr_target_abort,
    // dma engine side
    input  wire logic        dma_frame_start,
    output var  logic        dma_run,
    output var  logic [5:0]  tx_burst_words,
    output var  logic        burst_unlimited,
    output var  logic        tx_udp_sum_gen,
    output var  logic        tx_tcp_sum_gen,
    output var  logic        tx_ip_sum_gen,
    output var  logic        tx_dma_stopped,
    // receive buffer level, full duplex flag
    input  wire logic        rx_buf_near_full,
    input  wire logic        full_duplex,
    // link domain
    input  wire logic        link_clk,
    input  wire logic        link_rst,
    input  wire logic        tx_in_valid,
    input  wire logic [7:0]  tx_in_data,
    input  wire logic        tx_in_last,
    output var  logic        tx_in_ready,
    output var  logic        tx_out_valid,
    output var  logic [7:0]  tx_out_data,
    output var  logic        tx_out_last,
    output var  logic        tx_out_append_fcs,
    output var  logic        tx_pause_req,
    output var  logic        tx_backpressure
);
    `include "eth_tx_ctrl_defines.svh"

    typedef struct packed {
        logic [31:0] txc;
        tx_state_e   state;
        logic [31:0] rdata;
        logic        ack;
        logic        abort;
        logic        busy;
        logic        done_tgl_seen;
    } st_s;

    st_s  st_ff;
    st_s  nxt_st;

    logic       be_legal;
    logic       hit;
    logic [31:0] lane_mask;
    logic [31:0] wmask;
    logic       done_tgl_sys;
    logic       frame_done_link;
    logic       done_tgl_ff;
    logic       nxt_done_tgl;
    logic [2:0] ctl_link;
    logic       near_full_sync;
    logic       duplex_sync;

    // byte, aligned halfword or full word only
    always_comb begin
        case (pci_byte_enables)
            4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf: be_legal = 1'b1;
            default:                               be_legal = 1'b0;
        endcase
    end

    assign hit = (csr_addr == `TXC_OFFSET);
    // little-endian: enable n covers bits 8n+7:8n
    assign lane_mask = {{8{pci_byte_enables[3]}}, {8{pci_byte_enables[2]}},
                        {8{pci_byte_enables[1]}}, {8{pci_byte_enables[0]}}};
    assign wmask = lane_mask & `TXC_WRITE_MASK;

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.ack   = 1'b0;
        nxt_st.abort = 1'b0;
        nxt_st.done_tgl_seen = done_tgl_sys;
        if (csr_sel && csr_write) begin
            if (!be_legal) begin
                nxt_st.abort = 1'b1;
            end else begin
                nxt_st.ack = 1'b1;
                if (hit) begin
                    nxt_st.txc = (st_ff.txc & ~wmask) | (csr_wdata & wmask);
                end
            end
        end else if (csr_sel) begin
            nxt_st.ack   = 1'b1;
            nxt_st.rdata = hit ? st_ff.txc : 32'h0000_0000;
        end
        // frame in progress tracking; a start outranks an end in the same cycle
        if (done_tgl_sys != st_ff.done_tgl_seen) begin
            nxt_st.busy = 1'b0;
        end
        if (dma_frame_start && st_ff.state != TX_STOPPED) begin
            nxt_st.busy = 1'b1;
        end
        case (st_ff.state)
            TX_STOPPED: begin
                if (st_ff.txc[`TXC_EN_BIT]) begin
                    nxt_st.state = TX_RUNNING;
                end
            end
            TX_RUNNING: begin
                if (!st_ff.txc[`TXC_EN_BIT]) begin
                    nxt_st.state = nxt_st.busy ? TX_STOPPING : TX_STOPPED;
                end
            end
            TX_STOPPING: begin
                if (!nxt_st.busy) begin
                    nxt_st.state = st_ff.txc[`TXC_EN_BIT] ? TX_RUNNING : TX_STOPPED;
                end
            end
            default: nxt_st.state = TX_STOPPED;
        endcase
        if (srst) begin
            nxt_st       = '0;
            nxt_st.txc   = `TXC_RESET;
            nxt_st.state = TX_STOPPED;
            nxt_st.done_tgl_seen = done_tgl_sys;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_ff <= nxt_st;
    end

    assign csr_rdata        = st_ff.rdata;
    assign csr_ack          = st_ff.ack;
    assign csr_target_abort = st_ff.abort;
    // new frames start only while running
    assign dma_run          = (st_ff.state == TX_RUNNING);
    assign tx_dma_stopped   = (st_ff.state == TX_STOPPED);
    assign tx_burst_words   = st_ff.txc[`TXC_BURST_HI:`TXC_BURST_LO];
    assign burst_unlimited  = (tx_burst_words == 6'h00);
    assign tx_udp_sum_gen   = st_ff.txc[`TXC_UDP_BIT];
    assign tx_tcp_sum_gen   = st_ff.txc[`TXC_TCP_BIT];
    assign tx_ip_sum_gen    = st_ff.txc[`TXC_IP_BIT];

    // control levels into the link domain
    sync_level #(.WIDTH(3)) u_ctl_sync (
        .clk  (link_clk),
        .srst (link_rst),
        .din  ({st_ff.txc[`TXC_FLOW_BIT], st_ff.txc[`TXC_PAD_BIT], st_ff.txc[`TXC_FCS_BIT]}),
        .dout (ctl_link)
    );
    sync_level #(.WIDTH(2)) u_stat_sync (
        .clk  (link_clk),
        .srst (link_rst),
        .din  ({rx_buf_near_full, full_duplex}),
        .dout ({near_full_sync, duplex_sync})
    );

    tx_link_pad u_pad (
        .link_clk   (link_clk),
        .link_rst   (link_rst),
        .pad_en     (ctl_link[1]),
        .fcs_en     (ctl_link[0]),
        .in_valid   (tx_in_valid),
        .in_data    (tx_in_data),
        .in_last    (tx_in_last),
        .in_ready   (tx_in_ready),
        .out_valid  (tx_out_valid),
        .out_data   (tx_out_data),
        .out_last   (tx_out_last),
        .out_fcs    (tx_out_append_fcs),
        .frame_done (frame_done_link)
    );

    // frame-end event as a toggle back to the system clock
    always_comb begin
        nxt_done_tgl = done_tgl_ff ^ frame_done_link;
        if (link_rst) begin
            nxt_done_tgl = 1'b0;
        end
    end
    always_ff @(posedge link_clk) begin
        done_tgl_ff <= nxt_done_tgl;
    end
    sync_level #(.WIDTH(1)) u_done_sync (
        .clk  (sys_clk),
        .srst (srst),
        .din  (done_tgl_ff),
        .dout (done_tgl_sys)
    );

    // flow control chooses pause or backpressure by duplex
    assign tx_pause_req    = ctl_link[2] && duplex_sync && near_full_sync;
    assign tx_backpressure = ctl_link[2] && !duplex_sync && near_full_sync;
endmodule // eth_tx_dma_ctrl
`default_nettype wire

// ### common/eth_tx_ctrl_defines.svh
// register offsets, field positions and reset values of the transmit dma control block
`ifndef ETH_TX_CTRL_DEFINES_SVH
`define ETH_TX_CTRL_DEFINES_SVH
`define TXC_OFFSET        8'h00
`define TXC_RESET         32'h0000_0000
`define TXC_BURST_HI      29
`define TXC_BURST_LO      24
`define TXC_UDP_BIT       18
`define TXC_TCP_BIT       17
`define TXC_IP_BIT        16
`define TXC_FLOW_BIT      9
`define TXC_PAD_BIT       2
`define TXC_FCS_BIT       1
`define TXC_EN_BIT        0
`define TXC_WRITE_MASK    32'h3f07_0207
`define MIN_FRAME_BYTES   7'h40
`define FCS_BYTES         7'h04
`endif

// ### common/eth_tx_ctrl_pkg.sv
// types shared by the transmit dma control block
package eth_tx_ctrl_pkg;
    typedef enum logic [1:0] {TX_STOPPED, TX_RUNNING, TX_STOPPING} tx_state_e;
    typedef logic [5:0] burst_t;
endpackage

// ### verilog/sync_level.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none
module sync_level #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] din,
    output var  logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } st_s;
    st_s st_ff;
    st_s nxt_st;
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.meta = din;
        nxt_st.sync = st_ff.meta;
        if (srst) begin
            nxt_st = '0;
        end
    end
    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end
    assign dout = st_ff.sync;
endmodule // sync_level
`default_nettype wire

// ### verilog/tx_link_pad.sv
// link-side short frame padding and fcs marking
`timescale 1ns/1ns
`default_nettype none
module tx_link_pad (
    input  wire logic       link_clk,
    input  wire logic       link_rst,
    input  wire logic       pad_en,
    input  wire logic       fcs_en,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    input  wire logic       in_last,
    output var  logic       in_ready,
    output var  logic       out_valid,
    output var  logic [7:0] out_data,
    output var  logic       out_last,
    output var  logic       out_fcs,
    output var  logic       frame_done
);
    `include "eth_tx_ctrl_defines.svh"
    typedef struct packed {
        logic [6:0] count;
        logic       padding;
        logic       valid;
        logic [7:0] data;
        logic       last;
        logic       fcs;
        logic       done;
    } st_s;
    st_s  st_ff;
    st_s  nxt_st;
    logic pad_need;
    // padding fills up to the minimum less the appended fcs
    assign pad_need = pad_en && (st_ff.count < (`MIN_FRAME_BYTES - `FCS_BYTES - 7'h01));
    assign in_ready = !st_ff.padding;
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.valid = 1'b0;
        nxt_st.last  = 1'b0;
        nxt_st.done  = 1'b0;
        if (st_ff.padding) begin
            nxt_st.valid = 1'b1;
            nxt_st.data  = 8'h00;
            if (st_ff.count >= (`MIN_FRAME_BYTES - `FCS_BYTES - 7'h01)) begin
                nxt_st.last    = 1'b1;
                nxt_st.padding = 1'b0;
                nxt_st.count   = 7'h00;
                nxt_st.done    = 1'b1;
            end else begin
                nxt_st.count = st_ff.count + 7'h01;
            end
        end else if (in_valid) begin
            nxt_st.valid = 1'b1;
            nxt_st.data  = in_data;
            nxt_st.fcs   = fcs_en || pad_en;
            if (in_last && pad_need) begin
                nxt_st.padding = 1'b1;
                nxt_st.count   = st_ff.count + 7'h01;
            end else if (in_last) begin
                nxt_st.last  = 1'b1;
                nxt_st.count = 7'h00;
                nxt_st.done  = 1'b1;
            end else if (st_ff.count != 7'h7f) begin
                nxt_st.count = st_ff.count + 7'h01;
            end
        end
        if (link_rst) begin
            nxt_st = '0;
        end
    end
    always_ff @(posedge link_clk) begin
        st_ff <= nxt_st;
    end
    assign out_valid  = st_ff.valid;
    assign out_data   = st_ff.data;
    assign out_last   = st_ff.last;
    assign out_fcs    = st_ff.fcs;
    assign frame_done = st_ff.done;
endmodule // tx_link_pad
`default_nettype wire

// ### tb/eth_tx_dma_ctrl_properties.sv
// concurrent checks on the ports of the transmit dma control block
`timescale 1ns/1ns
`default_nettype none
module eth_tx_dma_ctrl_checker (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        csr_sel,
    input wire logic        csr_write,
    input wire logic [7:0]  csr_addr,
    input wire logic [3:0]  pci_byte_enables,
    input wire logic [31:0] csr_wdata,
    input wire logic [31:0] csr_rdata,
    input wire logic        csr_ack,
    input wire logic        csr_target_abort,
    input wire logic        dma_run,
    input wire logic [5:0]  tx_burst_words,
    input wire logic        burst_unlimited,
    input wire logic        tx_dma_stopped,
    input wire logic        link_clk,
    input wire logic        link_rst,
    input wire logic        tx_in_valid,
    input wire logic [7:0]  tx_in_data,
    input wire logic        tx_in_ready,
    input wire logic        tx_out_valid,
    input wire logic [7:0]  tx_out_data
);
    logic bad_be;
    logic wr0;
    assign bad_be = !(pci_byte_enables inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf});
    assign wr0 = csr_sel && csr_write && !bad_be && csr_addr == 8'h00;
    good_ack_a: assert property (@(posedge sys_clk) disable iff (srst)
        csr_sel && !(csr_write && bad_be) |=> csr_ack && !csr_target_abort) else $error("access not acked");
    bad_abort_a: assert property (@(posedge sys_clk) disable iff (srst)
        csr_sel && csr_write && bad_be |=> csr_target_abort && !csr_ack) else $error("illegal write not aborted");
    lone_answer_a: assert property (@(posedge sys_clk) disable iff (srst)
        csr_ack || csr_target_abort |-> $past(csr_sel)) else $error("answer without request");
    burst_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr0 && pci_byte_enables[3] |-> ##2 burst_unlimited == ($past(csr_wdata[29:24], 2) == 6'h00))
        else $error("unlimited flag wrong");
    burst_field_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr0 && pci_byte_enables == 4'hf |-> ##2 tx_burst_words == $past(csr_wdata[29:24], 2))
        else $error("burst field not taken");
    run_start_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr0 && pci_byte_enables[0] && csr_wdata[0] |-> ##2 dma_run) else $error("enable did not run");
    stop_ignored_a: assert property (@(posedge sys_clk) disable iff (srst)
        wr0 && pci_byte_enables[0] && !csr_wdata[0] && tx_dma_stopped |=> ##1 tx_dma_stopped && !dma_run)
        else $error("stop while stopped acted");
    rsvd_zero_a: assert property (@(posedge sys_clk) disable iff (srst)
        csr_ack && !$past(csr_write) |-> (csr_rdata & 32'hc0f8_fdf8) == 32'h0) else $error("reserved bits set");
    link_pass_a: assert property (@(posedge link_clk) disable iff (link_rst)
        tx_in_valid && tx_in_ready |=> tx_out_valid && tx_out_data == $past(tx_in_data))
        else $error("link byte not passed");
endmodule // eth_tx_dma_ctrl_checker
bind eth_tx_dma_ctrl eth_tx_dma_ctrl_checker chk (.sys_clk, .srst, .csr_sel, .csr_write, .csr_addr,
    .pci_byte_enables, .csr_wdata, .csr_rdata, .csr_ack, .csr_target_abort, .dma_run, .tx_burst_words,
    .burst_unlimited, .tx_dma_stopped, .link_clk, .link_rst, .tx_in_valid, .tx_in_data, .tx_in_ready,
    .tx_out_valid, .tx_out_data);
`default_nettype wire

// ### tb/csr_host_model.sv
// register bus host issuing single register cycles
`timescale 1ns/1ns
`default_nettype none
module csr_host_model (
    input  wire logic        sys_clk,
    input  wire logic        csr_ack,
    input  wire logic        csr_target_abort,
    output var  logic        csr_sel,
    output var  logic        csr_write,
    output var  logic [7:0]  csr_addr,
    output var  logic [3:0]  pci_byte_enables,
    output var  logic [31:0] csr_wdata
);
    initial {csr_sel, csr_write, csr_addr, pci_byte_enables, csr_wdata} = '0;
    task automatic cycle(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        {csr_sel, csr_write, csr_addr, pci_byte_enables, csr_wdata} <= {1'b1, w, a, be, d};
        @(posedge sys_clk);
        csr_sel <= 1'b0;
        // unselected lines never keep the last value
        {csr_write, csr_addr, pci_byte_enables, csr_wdata} <= ~{w, a, be, d};
        while (csr_ack !== 1'b1 && csr_target_abort !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            n++;
        end
    endtask
endmodule // csr_host_model
`default_nettype wire

// ### tb/eth_tx_dma_ctrl_test.sv
// self-checking bench for the transmit dma control block
`timescale 1ns/1ns
`default_nettype none
`include "eth_tx_ctrl_defines.svh"
module eth_tx_dma_ctrl_test;
    logic        sys_clk = 1'b0, srst = 1'b1, link_clk = 1'b0, link_rst = 1'b1;
    logic        csr_sel, csr_write, csr_ack, csr_target_abort, dma_run, burst_unlimited, tx_dma_stopped;
    logic        tx_udp_sum_gen, tx_tcp_sum_gen, tx_ip_sum_gen, tx_in_ready, tx_out_valid, tx_out_last;
    logic        tx_out_append_fcs, tx_pause_req, tx_backpressure;
    logic        dma_frame_start = 1'b0, rx_buf_near_full = 1'b0, full_duplex = 1'b0;
    logic        tx_in_valid = 1'b0, tx_in_last = 1'b0;
    logic [7:0]  csr_addr, tx_out_data, tx_in_data = 8'h00;
    logic [3:0]  pci_byte_enables;
    logic [5:0]  tx_burst_words;
    logic [31:0] csr_wdata, csr_rdata, rnd = 32'h2153;
    logic [33:0] csr_q[$], nt;
    logic [9:0]  out_q[$], ln;
    int          n_mismatch = 0, num_checks = 0;
    initial forever #4 sys_clk = ~sys_clk;
    initial begin
        #3;
        forever #24 link_clk = ~link_clk;
    end
    eth_tx_dma_ctrl dut (.sys_clk, .srst, .csr_sel, .csr_write, .csr_addr, .pci_byte_enables, .csr_wdata,
        .csr_rdata, .csr_ack, .csr_target_abort, .dma_frame_start, .dma_run, .tx_burst_words, .burst_unlimited,
        .tx_udp_sum_gen, .tx_tcp_sum_gen, .tx_ip_sum_gen, .tx_dma_stopped, .rx_buf_near_full, .full_duplex,
        .link_clk, .link_rst, .tx_in_valid, .tx_in_data, .tx_in_last, .tx_in_ready, .tx_out_valid,
        .tx_out_data, .tx_out_last, .tx_out_append_fcs, .tx_pause_req, .tx_backpressure);
    csr_host_model host (.sys_clk, .csr_ack, .csr_target_abort, .csr_sel, .csr_write, .csr_addr,
        .pci_byte_enables, .csr_wdata);
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d, input logic ab);
        csr_q.push_back({1'b0, ab, 32'h0});
        host.cycle(1'b1, a, be, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [3:0] be, input logic [31:0] exp);
        csr_q.push_back({2'b10, exp});
        host.cycle(1'b0, a, be, 32'h0);
    endtask
    task automatic send(input int len, input logic pad, input logic fcs);
        int i;
        int tot;
        tot = (pad && len < 60) ? 60 : len;
        for (i = 0; i < tot; i++) out_q.push_back({i < len ? 8'(i) ^ 8'ha5 : 8'h00, i == tot - 1, pad | fcs});
        @(posedge link_clk);
        for (i = 0; i < len; i++) begin
            {tx_in_valid, tx_in_data, tx_in_last} <= {1'b1, 8'(i) ^ 8'ha5, i == len - 1};
            @(posedge link_clk);
            while (tx_in_ready !== 1'b1) @(posedge link_clk);
        end
        {tx_in_valid, tx_in_data} <= {1'b0, ~tx_in_data};
        for (i = 0; i < 400 && out_q.size() != 0; i++) @(posedge link_clk);
        check("frame drained", out_q.size(), 0);
    endtask
    always @(posedge sys_clk) if (csr_ack === 1'b1 || csr_target_abort === 1'b1) begin
        nt = csr_q.pop_front();
        check("abort", csr_target_abort, nt[32]);
        if (nt[33]) check("rdata", csr_rdata, nt[31:0]);
    end
    always @(posedge link_clk) if (tx_out_valid === 1'b1) begin
        ln = out_q.pop_front();
        check("link byte", {tx_out_data, tx_out_last, tx_out_append_fcs}, ln);
    end
    initial begin
        repeat (4) @(posedge link_clk);
        link_rst <= 1'b0;
    end
    // whole run needs about 12 us
    initial begin
        #100000;
        n_mismatch++;
        print_verdict();
    end
    initial begin : main
        logic [31:0] v;
        int k;
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (30) @(posedge sys_clk);
        rd(8'h00, 4'hf, `TXC_RESET);
        rnd = xs(rnd);
        v = {2'b00, 6'h01 << rnd[26:24] % 6, rnd[23:0] & 24'hff_fff8};
        v[1] = |v[18:16];
        wr(8'h00, 4'hf, v, 1'b0);
        rd(8'h00, 4'h5, v & `TXC_WRITE_MASK);
        check("burst", tx_burst_words, v[29:24]);
        check("sum gen", {tx_udp_sum_gen, tx_tcp_sum_gen, tx_ip_sum_gen}, v[18:16]);
        wr(8'h00, 4'h8, 32'h0000_0000, 1'b0);
        v[29:24] = 6'h00;
        for (k = 0; k < 16; k++) if (!(k inside {1, 2, 4, 8, 3, 12, 15})) wr(8'h00, 4'(k), 32'hffff_ffff, 1'b1);
        rd(8'h00, 4'hf, v & `TXC_WRITE_MASK);
        check("unlimited", burst_unlimited, 1'b1);
        rd(8'h08, 4'hf, 32'h0);
        rx_buf_near_full <= 1'b1;
        for (k = 0; k < 3; k++) begin
            wr(8'h00, 4'h3, {22'h0, k < 2, 9'h0}, 1'b0);
            full_duplex <= k == 0;
            repeat (40) @(posedge sys_clk);
            check("pause", tx_pause_req, k == 0);
            check("backpressure", tx_backpressure, k == 1);
        end
        wr(8'h00, 4'h1, 32'h5, 1'b0);
        dma_frame_start <= 1'b1;
        @(posedge sys_clk);
        dma_frame_start <= 1'b0;
        check("running", dma_run, 1'b1);
        wr(8'h00, 4'h1, 32'h4, 1'b0);
        repeat (4) @(posedge sys_clk);
        check("stopped early", tx_dma_stopped, 1'b0);
        send(3, 1'b1, 1'b0);
        for (k = 0; k < 50 && tx_dma_stopped !== 1'b1; k++) @(posedge sys_clk);
        check("stopped", tx_dma_stopped, 1'b1);
        wr(8'h00, 4'h1, 32'h6, 1'b0);
        send(59, 1'b1, 1'b1);
        wr(8'h00, 4'h1, 32'h2, 1'b0);
        repeat (4) @(posedge link_clk);
        send(61, 1'b0, 1'b1);
        wr(8'h00, 4'h1, 32'h0, 1'b0);
        repeat (4) @(posedge link_clk);
        send(5, 1'b0, 1'b0);
        check("stopped", tx_dma_stopped, 1'b1);
        check("notes left", csr_q.size(), 0);
        print_verdict();
    end
endmodule // eth_tx_dma_ctrl_test
`default_nettype wire
